// [fect_flash_test.sv]
`timescale 1ns/1ps
module fect_flash_test
    import fect_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // array cell condition, one level per word
    input wire logic [DEPTH-1:0] weak_word,
    // fault and event outputs
    output logic irq,
    output logic mce,
    output logic fault_out
);
    fect_state_e state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [AW-1:0] idx_ff, nxt_idx, addr_ff, nxt_addr;
    logic [DW-1:0] arr_d_ff [DEPTH];
    logic [DW-1:0] nxt_arr_d [DEPTH];
    logic [CW-1:0] arr_c_ff [DEPTH];
    logic [CW-1:0] nxt_arr_c [DEPTH];
    logic [31:0] wlo_ff, nxt_wlo, whi_ff, nxt_whi, rlo_ff, nxt_rlo, rhi_ff, nxt_rhi;
    logic [31:0] tdata_ff, nxt_tdata, tres_ff, nxt_tres, rdata_ff, nxt_rdata;
    logic [SIG_W-1:0] tmisr_ff, nxt_tmisr, amisr_ff, nxt_amisr;
    logic [1:0] tfl_ff, nxt_tfl;
    logic mre_ff, nxt_mre, sbcv_ff, nxt_sbcv, echk_ff, nxt_echk, adone_ff, nxt_adone;
    logic pgood_ff, nxt_pgood, perr_ff, nxt_perr;
    logic [IST_W-1:0] ist_ff, nxt_ist, imask_ff, nxt_imask, ist_set;
    logic irq_ff, nxt_irq, mce_ff, nxt_mce, fault_ff, nxt_fault;
    logic [DW-1:0] rd_word, arr_corr;
    logic [CW-1:0] enc_chk;
    logic [TDW-1:0] tst_corr;
    logic arr_sbe, arr_dbe, tst_sbe, tst_dbe;
    logic idle, cmd_wr, prog_go, erase_go, read_go, trig, erased, prog_done;

    assign idle = (state_ff == FECT_IDLE);
    assign cmd_wr = wr && (addr == OFS_CMD) && idle;
    assign prog_go = cmd_wr && wdata[CMD_PROG];
    assign erase_go = cmd_wr && !wdata[CMD_PROG] && wdata[CMD_ERASE];
    assign read_go = cmd_wr && !wdata[CMD_PROG] && !wdata[CMD_ERASE] && wdata[CMD_READ];
    assign trig = wr && (addr == OFS_TCHECK) && echk_ff;
    assign erased = (&arr_d_ff[addr_ff]) && (&arr_c_ff[addr_ff]);
    assign prog_done = (state_ff == FECT_PROG) && (cnt_ff == '0);

    // shifted sense margin makes a weak cell read wrong
    assign rd_word = arr_d_ff[addr_ff] ^ {{(DW - 1){1'b0}}, mre_ff && weak_word[addr_ff]};

    fect_secded #(.DW(DW), .CW(CW)) u_arr_ecc (
        .data_in(rd_word),
        .check_in(arr_c_ff[addr_ff]),
        .check_gen(),
        .data_out(arr_corr),
        .single_err(arr_sbe),
        .double_err(arr_dbe)
    );

    fect_secded #(.DW(DW), .CW(CW)) u_enc (
        .data_in({whi_ff, wlo_ff}),
        .check_in('0),
        .check_gen(enc_chk),
        .data_out(),
        .single_err(),
        .double_err()
    );

    // test copy of the correction logic, 32 data and 7 check bits
    fect_secded #(.DW(TDW), .CW(TCW)) u_tst_ecc (
        .data_in(tdata_ff),
        .check_in(wdata[TCW-1:0]),
        .check_gen(),
        .data_out(tst_corr),
        .single_err(tst_sbe),
        .double_err(tst_dbe)
    );

    function automatic logic [SIG_W-1:0] misr_step(input logic [SIG_W-1:0] s, input logic [SIG_W-1:0] v);
        misr_step = {s[SIG_W-2:0], 1'b0} ^ (s[SIG_W-1] ? MISR_POLY : '0) ^ v;
    endfunction

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_idx = idx_ff;
        nxt_arr_d = arr_d_ff;
        nxt_arr_c = arr_c_ff;
        nxt_addr = addr_ff;
        nxt_wlo = wlo_ff;
        nxt_whi = whi_ff;
        nxt_rlo = rlo_ff;
        nxt_rhi = rhi_ff;
        nxt_tdata = tdata_ff;
        nxt_tres = tres_ff;
        nxt_tfl = tfl_ff;
        nxt_tmisr = tmisr_ff;
        nxt_amisr = amisr_ff;
        nxt_mre = mre_ff;
        nxt_sbcv = sbcv_ff;
        nxt_echk = echk_ff;
        nxt_adone = adone_ff;
        nxt_pgood = pgood_ff;
        nxt_perr = perr_ff;
        nxt_imask = imask_ff;
        nxt_mce = 1'b0;
        nxt_fault = 1'b0;
        ist_set = '0;
        if (wr && idle) begin
            unique case (addr)
                OFS_ADDR: nxt_addr = wdata[AW-1:0];
                OFS_WLO: nxt_wlo = wdata;
                OFS_WHI: nxt_whi = wdata;
                default: ;
            endcase
        end
        if (wr) begin
            unique case (addr)
                OFS_UTEST: begin
                    nxt_mre = wdata[UT_MRE];
                    nxt_sbcv = wdata[UT_SBCV];
                    nxt_echk = wdata[UT_ECHK];
                    if (!wdata[UT_ECHK]) begin
                        nxt_tmisr = MISR_SEED;
                    end
                end
                OFS_TDATA: nxt_tdata = wdata;
                OFS_IMASK: nxt_imask = wdata[IST_W-1:0];
                default: ;
            endcase
        end
        // test results stay in test registers, no fault output
        if (trig) begin
            nxt_tres = tst_corr;
            nxt_tfl = {tst_dbe, tst_sbe};
            nxt_tmisr = misr_step(tmisr_ff, tst_corr ^ {22'h000000, tst_dbe, tst_sbe, 8'h00});
        end
        if (read_go) begin
            // corrected data returned whatever the visibility
            nxt_rlo = arr_corr[31:0];
            nxt_rhi = arr_corr[63:32];
            ist_set[IST_SBC] = arr_sbe && sbcv_ff;
            ist_set[IST_UNC] = arr_dbe;
            nxt_mce = arr_dbe;
            nxt_fault = arr_dbe;
        end
        if (erase_go) begin
            nxt_arr_d[addr_ff] = '1;
            nxt_arr_c[addr_ff] = '1;
        end
        unique case (state_ff)
            FECT_IDLE: begin
                if (prog_go) begin
                    nxt_state = FECT_PROG;
                    nxt_cnt = 4'(PROG_CYC - 1);
                    nxt_pgood = 1'b0;
                    nxt_perr = !erased;
                end else if (wr && addr == OFS_UTEST && wdata[UT_AGO]) begin
                    nxt_state = FECT_AISC;
                    nxt_idx = '0;
                    nxt_amisr = MISR_SEED;
                    nxt_adone = 1'b0;
                end
            end
            FECT_PROG: begin
                if (prog_done) begin
                    // cells only move from erased to programmed
                    nxt_arr_d[addr_ff] = arr_d_ff[addr_ff] & {whi_ff, wlo_ff};
                    // a reprogram leaves the check cells alone, so the old check pattern stays
                    nxt_arr_c[addr_ff] = perr_ff ? arr_c_ff[addr_ff] : (arr_c_ff[addr_ff] & enc_chk);
                    nxt_pgood = !perr_ff;
                    ist_set[IST_PROG] = 1'b1;
                    nxt_state = FECT_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            FECT_AISC: begin
                // raw array word, not through the decoder: both data halves and the check bits
                nxt_amisr = misr_step(amisr_ff, arr_d_ff[idx_ff][31:0] ^ arr_d_ff[idx_ff][63:32]
                    ^ {24'h000000, arr_c_ff[idx_ff]});
                nxt_idx = idx_ff + AW'(1);
                if (idx_ff == AW'(DEPTH - 1)) begin
                    nxt_adone = 1'b1;
                    ist_set[IST_AISC] = 1'b1;
                    nxt_state = FECT_IDLE;
                end
            end
            default: nxt_state = FECT_IDLE;
        endcase
        // a set in the clearing cycle wins
        nxt_ist = (ist_ff & ~((wr && addr == OFS_ISTAT) ? wdata[IST_W-1:0] : '0)) | ist_set;
        nxt_irq = |(nxt_ist & nxt_imask);
        nxt_rdata = 32'h00000000;
        if (rd) begin
            unique case (addr)
                OFS_MCFG: nxt_rdata = {29'h00000000, !idle, perr_ff, pgood_ff};
                OFS_UTEST: nxt_rdata = {27'h0000000, adone_ff, 1'b0, echk_ff, sbcv_ff, mre_ff};
                OFS_ADDR: nxt_rdata = 32'(addr_ff);
                OFS_WLO: nxt_rdata = wlo_ff;
                OFS_WHI: nxt_rdata = whi_ff;
                OFS_RLO: nxt_rdata = rlo_ff;
                OFS_RHI: nxt_rdata = rhi_ff;
                OFS_TDATA: nxt_rdata = tdata_ff;
                OFS_TRES: nxt_rdata = tres_ff;
                OFS_TCHECK: nxt_rdata = {22'h000000, tfl_ff, 8'h00};
                OFS_TMISR: nxt_rdata = tmisr_ff;
                OFS_AMISR: nxt_rdata = amisr_ff;
                OFS_ISTAT: nxt_rdata = {28'h0000000, ist_ff};
                OFS_IMASK: nxt_rdata = {28'h0000000, imask_ff};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= FECT_IDLE;
            cnt_ff <= 4'h0;
            idx_ff <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                arr_d_ff[i] <= '1;
                arr_c_ff[i] <= '1;
            end
            addr_ff <= '0;
            wlo_ff <= 32'h00000000;
            whi_ff <= 32'h00000000;
            rlo_ff <= 32'h00000000;
            rhi_ff <= 32'h00000000;
            tdata_ff <= 32'h00000000;
            tres_ff <= 32'h00000000;
            tfl_ff <= 2'h0;
            tmisr_ff <= MISR_SEED;
            amisr_ff <= MISR_SEED;
            mre_ff <= 1'b0;
            sbcv_ff <= 1'b0;
            echk_ff <= 1'b0;
            adone_ff <= 1'b0;
            pgood_ff <= 1'b0;
            perr_ff <= 1'b0;
            ist_ff <= '0;
            imask_ff <= '0;
            irq_ff <= 1'b0;
            mce_ff <= 1'b0;
            fault_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            idx_ff <= nxt_idx;
            arr_d_ff <= nxt_arr_d;
            arr_c_ff <= nxt_arr_c;
            addr_ff <= nxt_addr;
            wlo_ff <= nxt_wlo;
            whi_ff <= nxt_whi;
            rlo_ff <= nxt_rlo;
            rhi_ff <= nxt_rhi;
            tdata_ff <= nxt_tdata;
            tres_ff <= nxt_tres;
            tfl_ff <= nxt_tfl;
            tmisr_ff <= nxt_tmisr;
            amisr_ff <= nxt_amisr;
            mre_ff <= nxt_mre;
            sbcv_ff <= nxt_sbcv;
            echk_ff <= nxt_echk;
            adone_ff <= nxt_adone;
            pgood_ff <= nxt_pgood;
            perr_ff <= nxt_perr;
            ist_ff <= nxt_ist;
            imask_ff <= nxt_imask;
            irq_ff <= nxt_irq;
            mce_ff <= nxt_mce;
            fault_ff <= nxt_fault;
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata = rdata_ff;
    assign irq = irq_ff;
    assign mce = mce_ff;
    assign fault_out = fault_ff;

    property p_prog_len;
        @(posedge clk) disable iff (!reset_n) prog_go |=> (state_ff == FECT_PROG) [*5] ##1 idle;
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("program length wrong");
    property p_pgood;
        @(posedge clk) disable iff (!reset_n) prog_done |=> (pgood_ff == !perr_ff) && ist_ff[IST_PROG];
    endproperty
    a_pgood: assert property (p_pgood) else $error("program good flag wrong");
    property p_reprog;
        @(posedge clk) disable iff (!reset_n) (prog_go && !erased) |=> perr_ff ##5 !pgood_ff;
    endproperty
    a_reprog: assert property (p_reprog) else $error("reprogram not flagged");
    property p_sbc_vis;
        @(posedge clk) disable iff (!reset_n) (read_go && arr_sbe && sbcv_ff) |=> ist_ff[IST_SBC] && !mce_ff;
    endproperty
    a_sbc_vis: assert property (p_sbc_vis) else $error("single-bit flag missing");
    property p_sbc_hid;
        @(posedge clk) disable iff (!reset_n)
            (read_go && arr_sbe && !sbcv_ff && !ist_ff[IST_SBC]) |=> !ist_ff[IST_SBC] && ({rhi_ff, rlo_ff} == $past(arr_corr));
    endproperty
    a_sbc_hid: assert property (p_sbc_hid) else $error("hidden correction misbehaves");
    property p_unc;
        @(posedge clk) disable iff (!reset_n) (read_go && arr_dbe) |=> mce_ff && fault_ff && ist_ff[IST_UNC] ##1 !mce_ff;
    endproperty
    a_unc: assert property (p_unc) else $error("uncorrectable read not raised");
    property p_test_quiet;
        @(posedge clk) disable iff (!reset_n) (trig && !read_go) |=> !$rose(fault_ff) || $past(read_go, 2);
    endproperty
    a_test_quiet: assert property (p_test_quiet) else $error("test fault leaked");
    property p_test_sig;
        @(posedge clk) disable iff (!reset_n) trig |=> (tres_ff == $past(tst_corr)) && (tfl_ff == $past({tst_dbe, tst_sbe}));
    endproperty
    a_test_sig: assert property (p_test_sig) else $error("test result not captured");
    property p_aisc;
        @(posedge clk) disable iff (!reset_n) (state_ff == FECT_AISC && idx_ff == '0) |-> ##[15:16] adone_ff;
    endproperty
    a_aisc: assert property (p_aisc) else $error("self check did not finish");
    property p_irq;
        @(posedge clk) disable iff (!reset_n) irq_ff |-> $past(|(nxt_ist & nxt_imask));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without cause");
    c_reprog: cover property (@(posedge clk) disable iff (!reset_n) prog_go && !erased);
    c_unc: cover property (@(posedge clk) disable iff (!reset_n) read_go && arr_dbe);
    c_aisc: cover property (@(posedge clk) disable iff (!reset_n) ist_set[IST_AISC]);
    c_tsbc: cover property (@(posedge clk) disable iff (!reset_n) trig && tst_sbe);
endmodule

// [fect_pkg.sv]
package fect_pkg;
    localparam int DW = 64;
    localparam int CW = 8;
    localparam int TDW = 32;
    localparam int TCW = 7;
    localparam int SIG_W = 32;
    localparam logic [7:0] OFS_MCFG = 8'h00;
    localparam logic [7:0] OFS_UTEST = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_WLO = 8'h0C;
    localparam logic [7:0] OFS_WHI = 8'h10;
    localparam logic [7:0] OFS_RLO = 8'h14;
    localparam logic [7:0] OFS_RHI = 8'h18;
    localparam logic [7:0] OFS_CMD = 8'h1C;
    localparam logic [7:0] OFS_TDATA = 8'h20;
    localparam logic [7:0] OFS_TCHECK = 8'h24;
    localparam logic [7:0] OFS_TRES = 8'h28;
    localparam logic [7:0] OFS_TMISR = 8'h2C;
    localparam logic [7:0] OFS_AMISR = 8'h30;
    localparam logic [7:0] OFS_ISTAT = 8'h34;
    localparam logic [7:0] OFS_IMASK = 8'h38;
    localparam int MCFG_PGOOD = 0;
    localparam int MCFG_PERR = 1;
    localparam int MCFG_BUSY = 2;
    localparam int UT_MRE = 0;
    localparam int UT_SBCV = 1;
    localparam int UT_ECHK = 2;
    localparam int UT_AGO = 3;
    localparam int UT_ADONE = 4;
    localparam int TR_SBC = 8;
    localparam int TR_DBL = 9;
    localparam int CMD_PROG = 0;
    localparam int CMD_ERASE = 1;
    localparam int CMD_READ = 2;
    localparam int IST_W = 4;
    localparam int IST_PROG = 0;
    localparam int IST_SBC = 1;
    localparam int IST_UNC = 2;
    localparam int IST_AISC = 3;
    localparam logic [SIG_W-1:0] MISR_POLY = 32'h04C11DB7;
    localparam logic [SIG_W-1:0] MISR_SEED = 32'hFFFFFFFF;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_TIME_NS = 20;
    localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        FECT_IDLE = 2'b00,
        FECT_PROG = 2'b01,
        FECT_AISC = 2'b10
    } fect_state_e;
endpackage

// [fect_secded.sv]
`timescale 1ns/1ps
module fect_secded #(
    parameter int DW = 64,
    parameter int CW = 8
) (
    // word under check
    input wire logic [DW-1:0] data_in,
    input wire logic [CW-1:0] check_in,
    // results
    output logic [CW-1:0] check_gen,
    output logic [DW-1:0] data_out,
    output logic single_err,
    output logic double_err
);
    // odd-weight columns of weight three or more, one per data bit
    function automatic logic [CW-1:0] col_code(input int idx);
        int n;
        int w;
        logic [CW-1:0] c;
        n = 0;
        col_code = '0;
        for (int v = 1; v < (1 << CW); v++) begin
            c = CW'(v);
            w = $countones(c);
            if (w >= 3 && (w % 2) == 1) begin
                if (n == idx) begin
                    col_code = c;
                end
                n++;
            end
        end
    endfunction

    logic [CW-1:0] contrib [DW];
    logic [DW-1:0] flip;
    logic [CW-1:0] syn;

    for (genvar j = 0; j < DW; j++) begin : g_col
        localparam logic [CW-1:0] COL = col_code(j);
        assign contrib[j] = data_in[j] ? COL : '0;
        assign flip[j] = (syn == COL);
    end

    // check bits from data bits only, no address term
    always_comb begin
        check_gen = '0;
        for (int j = 0; j < DW; j++) begin
            check_gen = check_gen ^ contrib[j];
        end
    end

    assign syn = check_gen ^ check_in;
    assign data_out = data_in ^ flip;
    assign single_err = (^syn) && (($onehot(syn)) || (|flip));
    assign double_err = (syn != '0) && !single_err;
endmodule

// [fect_core_model.sv]
`timescale 1ns/1ps
module fect_core_model (
    // clock
    input wire logic clk,
    // register port toward the block
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [31:0] rdata,
    // exception lines from the block
    input wire logic mce,
    input wire logic fault_out
);
    int mce_seen;
    int fault_seen;

    initial begin
        addr = 8'h00;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
        mce_seen = 0;
        fault_seen = 0;
    end

    // both exception lines are one-cycle pulses, so count every high cycle
    always @(posedge clk) begin
        if (mce === 1'b1) mce_seen++;
        if (fault_out === 1'b1) fault_seen++;
    end

    // one-cycle write; released data shows the inverse so stale values never look valid
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule

// [test_flash_ecc_integrity_test.sv]
`timescale 1ns/1ps
module test_flash_ecc_integrity_test;
    import fect_pkg::*;
    logic clk;
    logic reset_n;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wr;
    logic rd;
    logic irq;
    logic mce;
    logic fault_out;
    logic [15:0] weak_word;
    logic [31:0] sig;
    logic [31:0] v;
    int fails;
    int check_count;
    int m0;
    int f0;

    fect_flash_test #(.DEPTH(16)) dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .weak_word(weak_word), .irq(irq), .mce(mce), .fault_out(fault_out));
    fect_core_model core (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .mce(mce), .fault_out(fault_out));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // pin level, sampled once registered outputs have settled
    task automatic chk_pin(input logic got, input logic exp, input string what);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, {31'h0, exp}, what);
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        core.bus_write(a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        core.bus_read(a, d);
        chk(d, exp, what);
    endtask

    task automatic wait_bit(input logic [7:0] a, input int b, input logic lvl);
        logic [31:0] d;
        for (int i = 0; i < 100; i++) begin
            core.bus_read(a, d);
            if (d[b] === lvl) return;
        end
        fails++;
        $display("wrong value at %0t: wait on register %h timed out", $time, a);
    endtask

    task automatic prog(input logic [31:0] idx, input logic [63:0] d);
        w(OFS_ADDR, idx);
        w(OFS_WLO, d[31:0]);
        w(OFS_WHI, d[63:32]);
        w(OFS_CMD, 32'h00000001);
        wait_bit(OFS_MCFG, MCFG_BUSY, 1'b0);
    endtask

    task automatic fread(input logic [31:0] idx);
        w(OFS_ADDR, idx);
        w(OFS_CMD, 32'h00000004);
    endtask

    function automatic logic [31:0] step(input logic [31:0] s, input logic [31:0] x);
        return (s << 1) ^ (s[31] ? MISR_POLY : 32'h00000000) ^ x;
    endfunction

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #(4 * 20000);
        fails++;
        $display("wrong value at %0t: run did not finish", $time);
        complete_run();
    end

    initial begin
        fails = 0;
        check_count = 0;
        reset_n = 1'b0;
        weak_word = 16'h0000;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rchk(OFS_MCFG, 32'h00000000, "config after reset");
        rchk(OFS_ISTAT, 32'h00000000, "status after reset");
        rchk(OFS_TMISR, MISR_SEED, "test signature after reset");
        rchk(OFS_AMISR, MISR_SEED, "array signature after reset");
        $display("test reset values done");
        // erased words fold in as data halves cancelling and all-ones check bits
        w(OFS_UTEST, 32'h1 << UT_AGO);
        wait_bit(OFS_UTEST, UT_ADONE, 1'b1);
        sig = MISR_SEED;
        for (int i = 0; i < 16; i++) sig = step(sig, 32'h000000FF);
        rchk(OFS_AMISR, sig, "array signature");
        rchk(OFS_ISTAT, 32'h1 << IST_AISC, "self check event");
        w(OFS_ISTAT, 32'h1 << IST_AISC);
        $display("test array self check done");
        w(OFS_IMASK, 32'h1 << IST_PROG);
        prog(3, 64'h0000000000000001);
        rchk(OFS_MCFG, 32'h1 << MCFG_PGOOD, "program good");
        chk_pin(irq, 1'b1, "irq on program event");
        w(OFS_ISTAT, 32'h1 << IST_PROG);
        chk_pin(irq, 1'b0, "irq after clear");
        w(OFS_IMASK, 32'h0);
        prog(3, 64'h0);
        rchk(OFS_MCFG, 32'h1 << MCFG_PERR, "reprogram flags error");
        rchk(OFS_ISTAT, 32'h1 << IST_PROG, "masked event still set");
        chk_pin(irq, 1'b0, "irq masked");
        w(OFS_ISTAT, 32'h1 << IST_PROG);
        $display("test program status done");
        w(OFS_UTEST, 32'h1 << UT_SBCV);
        fread(3);
        rchk(OFS_RLO, 32'h1, "corrected low");
        rchk(OFS_RHI, 32'h0, "corrected high");
        rchk(OFS_ISTAT, 32'h1 << IST_SBC, "single bit reported");
        w(OFS_ISTAT, 32'h1 << IST_SBC);
        w(OFS_UTEST, 32'h0);
        fread(3);
        rchk(OFS_RLO, 32'h1, "corrected low, quiet");
        rchk(OFS_ISTAT, 32'h0, "single bit hidden");
        $display("test single bit done");
        m0 = core.mce_seen;
        f0 = core.fault_seen;
        prog(5, 64'h0000000000000003);
        prog(5, 64'h0);
        w(OFS_ISTAT, 32'h1 << IST_PROG);
        fread(5);
        rchk(OFS_ISTAT, 32'h1 << IST_UNC, "uncorrectable flagged");
        chk(32'(core.mce_seen - m0), 32'h1, "machine check pulses");
        chk(32'(core.fault_seen - f0), 32'h1, "fault pulses");
        w(OFS_ISTAT, 32'h1 << IST_UNC);
        $display("test double bit done");
        prog(7, 64'h0000000012345670);
        @(posedge clk);
        weak_word <= 16'h0080;
        w(OFS_UTEST, 32'h1 << UT_SBCV);
        fread(7);
        rchk(OFS_RLO, 32'h12345670, "normal read of weak word");
        rchk(OFS_ISTAT, 32'h1 << IST_PROG, "normal read of weak word clean");
        // the weak cell reads wrong under margin and the correction shows it
        w(OFS_UTEST, (32'h1 << UT_MRE) | (32'h1 << UT_SBCV));
        fread(7);
        rchk(OFS_RLO, 32'h12345670, "margin read of weak word");
        rchk(OFS_ISTAT, (32'h1 << IST_PROG) | (32'h1 << IST_SBC), "margin read flags weak cell");
        $display("test margin read done");
        w(OFS_UTEST, 32'h0);
        w(OFS_ISTAT, 32'h0000000F);
        m0 = core.mce_seen;
        f0 = core.fault_seen;
        w(OFS_UTEST, (32'h1 << UT_ECHK) | (32'h1 << UT_SBCV));
        w(OFS_TDATA, 32'h0);
        w(OFS_TCHECK, 32'h0);
        rchk(OFS_TRES, 32'h0, "clean vector");
        rchk(OFS_TCHECK, 32'h0, "clean vector flags");
        w(OFS_TDATA, 32'h00000020);
        w(OFS_TCHECK, 32'h0);
        rchk(OFS_TRES, 32'h0, "vector bit 5 corrected");
        rchk(OFS_TCHECK, 32'h1 << TR_SBC, "vector single flag");
        v = step(step(MISR_SEED, 32'h0), 32'h1 << TR_SBC);
        rchk(OFS_TMISR, v, "test signature");
        w(OFS_TDATA, 32'h00000003);
        w(OFS_TCHECK, 32'h0);
        rchk(OFS_TCHECK, 32'h1 << TR_DBL, "vector double flag");
        core.bus_read(OFS_ISTAT, v);
        chk(v & (32'h1 << IST_UNC), 32'h0, "test fault kept local");
        chk(32'(core.mce_seen - m0), 32'h0, "no machine check from test");
        chk(32'(core.fault_seen - f0), 32'h0, "no fault from test");
        w(OFS_UTEST, 32'h0);
        $display("test ecc logic check done");
        complete_run();
    end
endmodule
